/* verilog/fpc_fetch_pipe.sv */
// Purpose: Five-stage fetch pipeline with bus/block conflict stalls and conflict cache
// Assumes: Memory returns the fetch word in fetch2 while imem_data_en is high
// Notes: Decoder and address generators sit outside and answer on dec_info
`timescale 1ns/1ps

// Overview of operation
// RQ1: Instructions pass fetch1, fetch2, decode, address, execute in order.
// RQ2: Fetch1 picks next address from vector, branch or sequential and drives it.
// RQ3: Address stage drives data addresses and hands branch target to fetch.
// RQ4: Execute retires the instruction and strobes memory or register write.
// RQ5: All pipeline and sequencer addresses are 24 bits wide.
// RQ6: Sequential flow retires one instruction per cycle.
// RQ7: Program bus data access in execute conflicts with fetch of n+3.
// RQ8: Cache stores the displaced fetched instruction, not the data accessor.
// RQ9: Uncached bus conflict stalls one cycle, then fetches displaced instruction.
// RQ10: Cache looked up on each program bus data access; hit costs nothing.
// RQ11: Miss fetches next cycle; fill only when enabled and not frozen.
// RQ12: Thirty-two entries as sixteen two-way sets indexed by address bits 3-0.
// RQ13: Each entry has a valid bit.
// RQ14: Per-set replacement bit names the entry not filled or hit last.
// RQ15: Lookup compares both tags; hit updates replacement bit.
// RQ16: Miss fills entry named by replacement bit, then toggles it.
// RQ17: Block conflict when program, data or io accesses hit the code block.
// RQ18: Without a cache hit, single block conflict takes two cycles, dual takes three.
// RQ19: Program bus block conflicts fill the cache on a miss; data and io block conflicts do not.
// RQ20: Idle stops issue and holds until interrupt, then resumes.
// RQ21: After reset cache empty, unfrozen, enabled.
// RQ22: Mode bit 4 disables cache; conflicting fetches are then delayed.
// RQ23: Mode bit 19 freezes cache contents against fills.
// RQ24: Stall cycles hold earlier stages and put no bubble into execute.
module fpc_fetch_pipe
  import fpc_pkg::*;
#(
  parameter int BLK_LSB = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [ADDR_W-1:0] imem_addr,
  output logic imem_req,
  output logic imem_data_en,
  input wire logic [INSTR_W-1:0] imem_rdata,
  output logic [ADDR_W-1:0] dec_addr,
  output logic [INSTR_W-1:0] dec_instr,
  output logic dec_valid,
  input wire fpc_info_t dec_info,
  output logic [ADDR_W-1:0] progbus_addr,
  output logic progbus_addr_vld,
  output logic [ADDR_W-1:0] databus_addr,
  output logic databus_addr_vld,
  output logic progbus_xfer,
  output logic databus_xfer,
  input wire logic io_bus_req,
  input wire logic [ADDR_W-1:0] io_bus_addr,
  input wire logic irq_req,
  input wire logic [ADDR_W-1:0] irq_vector,
  output logic irq_ack,
  output logic [ADDR_W-1:0] irq_ret_addr,
  output logic exe_retire,
  output logic [ADDR_W-1:0] exe_addr,
  output logic [INSTR_W-1:0] exe_instr,
  output logic exe_mem_wr,
  output logic exe_reg_wr,
  output logic idle_active,
  output logic stall_active,
  output logic cache_hit
);

  generate
    if (BLK_LSB < IDX_W || BLK_LSB >= ADDR_W) begin : g_bad
      $error("BLK_LSB out of range");
    end
  endgenerate

  // Set index, way select and stall counter must cover the package sizes
  generate
    if (SETS != (1 << IDX_W)) begin : g_bad_sets
      $error("SETS must equal two to the power IDX_W");
    end
    if (WAYS != 2) begin : g_bad_ways
      $error("Replacement logic serves two ways only");
    end
    if (MAX_STALL != 2'h2) begin : g_bad_stall
      $error("Stall counter serves at most two extra cycles");
    end
  endgenerate

  fpc_state_t s;
  fpc_state_t n;

  logic [IDX_W-1:0] idx;
  logic h0;
  logic h1;
  logic hway;
  logic cache_on;
  logic hold_on;
  logic bus_cfl;
  logic hit;
  logic pblk;
  logic dblk;
  logic iblk;
  logic [1:0] nblk;
  logic [1:0] k_calc;
  logic [1:0] k_now;
  logic adv;
  logic br;
  logic wake;
  logic idle_ret;
  logic fetch;
  logic fill;
  logic [ADDR_W-1:0] f1_addr;
  logic [ADDR_W-1:0] code_blk;
  logic [INSTR_W-1:0] word;
  logic [31:0] rd_val;
  logic req;
  logic dslot;

  function automatic logic [ADDR_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    return a >> BLK_LSB;
  endfunction

  // Cache lookup on the fetch2 address
  assign idx = s.f2.addr[IDX_W-1:0]; // RQ12
  assign h0 = s.c.valid[idx][0] & (s.c.tag[idx][0] == s.f2.addr); // RQ13 RQ15
  assign h1 = s.c.valid[idx][1] & (s.c.tag[idx][1] == s.f2.addr); // RQ13 RQ15
  assign hway = h1 & ~h0;
  assign cache_on = ~s.mode[MODE_OFF_BIT]; // RQ22
  assign hold_on = s.mode[MODE_HOLD_BIT]; // RQ23

  // Conflict detection against the fetch of n+3
  assign bus_cfl = s.exe.valid & s.exe.info.prog_acc & s.f2.valid; // RQ7
  assign hit = bus_cfl & cache_on & (h0 | h1); // RQ10 RQ22
  assign code_blk = blk_of(s.f2.addr);
  assign pblk = bus_cfl & (blk_of(s.exe.info.prog_addr) == code_blk); // RQ17
  assign dblk = s.exe.valid & s.exe.info.data_acc & s.f2.valid
    & (blk_of(s.exe.info.data_addr) == code_blk); // RQ17
  assign iblk = io_bus_req & s.f2.valid & (blk_of(io_bus_addr) == code_blk); // RQ17
  assign nblk = 2'(pblk) + 2'(dblk) + 2'(iblk);

  // Extra cycles the executing instruction needs
  always_comb begin
    if (hit) begin
      k_calc = 2'h0; // RQ10
    end else if (nblk >= MAX_STALL) begin
      k_calc = MAX_STALL; // RQ18
    end else if (bus_cfl || nblk != 2'h0) begin
      k_calc = 2'h1; // RQ9 RQ18 RQ22
    end else begin
      k_calc = 2'h0; // RQ6
    end
  end

  assign k_now = (s.ph == 2'h0) ? k_calc : s.k;
  assign adv = (s.ph == k_now); // RQ24
  assign br = s.adr.valid & s.adr.info.branch; // RQ3
  assign wake = s.idle & irq_req; // RQ20
  assign idle_ret = adv & s.exe.valid & s.exe.info.idle; // RQ20
  assign fetch = adv & ~idle_ret & (~s.idle | irq_req); // RQ20 RQ24
  assign fill = adv & bus_cfl & ~hit & cache_on & ~hold_on; // RQ11 RQ19 RQ23

  // Fetch1 address selection
  always_comb begin
    if (wake) begin
      f1_addr = irq_vector; // RQ2
    end else if (br) begin
      f1_addr = s.adr.info.target; // RQ2 RQ3
    end else begin
      f1_addr = s.fptr; // RQ2
    end
  end

  assign word = hit ? s.c.data[idx][hway] : imem_rdata; // RQ10

  // Data phase slot of the data bus access behind a blocked program access
  assign dslot = pblk & dblk;

  // Register read mux
  always_comb begin
    rd_val = 32'h0;
    case (avs_address)
      REG_MODE: begin
        rd_val = s.mode;
      end
      REG_STAT: begin
        rd_val[STAT_IDLE_BIT] = s.idle;
        rd_val[STAT_STALL_BIT] = ~adv;
        rd_val[STAT_HIT_BIT] = s.last_hit;
      end
      default: begin
        rd_val = 32'h0;
      end
    endcase
  end

  assign req = avs_read | avs_write;

  always_comb begin
    n = s;
    if (s.ph == 2'h0) begin
      n.k = k_calc;
    end
    n.ph = adv ? 2'h0 : s.ph + 2'h1; // RQ18 RQ24
    if (adv) begin
      n.exe = s.adr; // RQ1 RQ6
      n.adr = s.dec; // RQ1
      n.adr.info = dec_info; // RQ3
      n.dec.valid = s.f2.valid; // RQ1
      n.dec.addr = s.f2.addr;
      n.dec.instr = word; // RQ8
      n.dec.info = '0;
      n.f2.valid = fetch; // RQ1
      n.f2.addr = f1_addr;
      n.f2.instr = '0;
      n.f2.info = '0;
      if (fetch) begin
        n.fptr = f1_addr + 24'h1; // RQ6
      end
      if (br) begin
        n.adr.valid = 1'b0; // RQ3
        n.dec.valid = 1'b0; // RQ3
      end
      if (idle_ret) begin
        n.exe.valid = 1'b0; // RQ20
        n.adr.valid = 1'b0; // RQ20
        n.dec.valid = 1'b0; // RQ20
        n.idle = 1'b1; // RQ20
        n.ret = s.exe.addr + 24'h1; // RQ20
      end
      if (wake) begin
        n.idle = 1'b0; // RQ20
      end
      if (bus_cfl) begin
        n.last_hit = hit;
      end
      if (hit) begin
        n.c.lru[idx] = ~hway; // RQ14 RQ15
      end
    end
    if (fill) begin
      n.c.valid[idx][s.c.lru[idx]] = 1'b1; // RQ8 RQ16
      n.c.tag[idx][s.c.lru[idx]] = s.f2.addr; // RQ8 RQ16
      n.c.data[idx][s.c.lru[idx]] = imem_rdata; // RQ16
      n.c.lru[idx] = ~s.c.lru[idx]; // RQ14 RQ16
    end
    // Avalon slave: one wait cycle, then the access completes
    n.ack = req & ~s.ack;
    if (avs_read && !s.ack) begin
      n.rdata = rd_val;
    end
    if (avs_write && s.ack && avs_address == REG_MODE) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          n.mode[8*b +: 8] = avs_writedata[8*b +: 8] & MODE_MASK[8*b +: 8]; // RQ22 RQ23
        end
      end
    end
    // Flush comes after the fill so that a same-cycle clear wins
    if (avs_write && s.ack && avs_address == REG_FLUSH
        && avs_byteenable[0] && avs_writedata[FLUSH_BIT]) begin
      n.c.valid = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0; // RQ21
      s.fptr <= RESET_VEC;
      s.mode <= MODE_RST; // RQ21
    end else begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = req & ~s.ack;
  assign imem_addr = f1_addr; // RQ2
  assign imem_req = fetch; // RQ2
  assign imem_data_en = adv & s.f2.valid & ~hit; // RQ9 RQ11
  assign dec_addr = s.dec.addr;
  assign dec_instr = s.dec.instr;
  assign dec_valid = s.dec.valid;
  assign progbus_addr = s.adr.info.prog_addr; // RQ3
  assign progbus_addr_vld = s.adr.valid & s.adr.info.prog_acc; // RQ3
  assign databus_addr = s.adr.info.data_addr; // RQ3
  assign databus_addr_vld = s.adr.valid & s.adr.info.data_acc; // RQ3
  assign progbus_xfer = s.exe.valid & s.exe.info.prog_acc & (s.ph == 2'h0); // RQ9 RQ18
  assign databus_xfer = s.exe.valid & s.exe.info.data_acc
    & (s.ph == 2'(dslot)); // RQ18
  assign irq_ack = wake;
  assign irq_ret_addr = s.ret;
  assign exe_retire = adv & s.exe.valid; // RQ4 RQ6
  assign exe_addr = s.exe.addr;
  assign exe_instr = s.exe.instr;
  assign exe_mem_wr = exe_retire & s.exe.info.mem_wr; // RQ4
  assign exe_reg_wr = exe_retire & s.exe.info.reg_wr; // RQ4
  assign idle_active = s.idle;
  assign stall_active = ~adv; // RQ24
  assign cache_hit = hit;

endmodule

/* common/fpc_pkg.sv */
// Purpose: Shared constants and carriers of the fetch pipeline with conflict cache
// Assumes: 24-bit instruction addresses, 48-bit instruction words
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
package fpc_pkg;
  localparam int ADDR_W = 24;
  localparam int INSTR_W = 48;
  localparam int SETS = 16;
  localparam int WAYS = 2;
  localparam int IDX_W = 4;
  localparam int BUS_AW = 4;
  localparam logic [BUS_AW-1:0] REG_MODE = 4'h0;
  localparam logic [BUS_AW-1:0] REG_STAT = 4'h4;
  localparam logic [BUS_AW-1:0] REG_FLUSH = 4'h8;
  localparam int MODE_OFF_BIT = 4;
  localparam int MODE_HOLD_BIT = 19;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK = 32'h0008_0010;
  localparam int STAT_IDLE_BIT = 0;
  localparam int STAT_STALL_BIT = 1;
  localparam int STAT_HIT_BIT = 2;
  localparam int FLUSH_BIT = 0;
  localparam logic [ADDR_W-1:0] RESET_VEC = 24'h00_0000;
  localparam logic [1:0] MAX_STALL = 2'h2;

  typedef struct packed {
    logic prog_acc;
    logic [ADDR_W-1:0] prog_addr;
    logic data_acc;
    logic [ADDR_W-1:0] data_addr;
    logic branch;
    logic [ADDR_W-1:0] target;
    logic idle;
    logic mem_wr;
    logic reg_wr;
  } fpc_info_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [INSTR_W-1:0] instr;
    fpc_info_t info;
  } fpc_stage_t;

  typedef struct packed {
    logic [SETS-1:0][WAYS-1:0] valid;
    logic [SETS-1:0][WAYS-1:0][ADDR_W-1:0] tag;
    logic [SETS-1:0][WAYS-1:0][INSTR_W-1:0] data;
    logic [SETS-1:0] lru;
  } fpc_cache_t;

  typedef struct packed {
    fpc_cache_t c;
    fpc_stage_t f2;
    fpc_stage_t dec;
    fpc_stage_t adr;
    fpc_stage_t exe;
    logic [ADDR_W-1:0] fptr;
    logic idle;
    logic [ADDR_W-1:0] ret;
    logic [1:0] ph;
    logic [1:0] k;
    logic [31:0] mode;
    logic ack;
    logic [31:0] rdata;
    logic last_hit;
  } fpc_state_t;
endpackage

/* testbench/fpc_fetch_pipe_assertions.sv */
// Purpose: Port checks of the fetch pipeline
// Assumes: One clock, synchronous reset
// Notes: Bound from the bench top
`timescale 1ns/1ps
module fpc_fetch_pipe_assertions
  import fpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [ADDR_W-1:0] imem_addr,
  input wire logic imem_req,
  input wire logic imem_data_en,
  input wire logic [ADDR_W-1:0] exe_addr,
  input wire logic irq_req,
  input wire logic [ADDR_W-1:0] irq_vector,
  input wire logic irq_ack,
  input wire logic exe_retire,
  input wire logic idle_active,
  input wire logic stall_active,
  input wire logic cache_hit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_reset_fetch: assert property ($fell(rst) |-> imem_req && imem_addr == RESET_VEC)
    else $error("first fetch wrong");
  a_bus_answer: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer late");
  a_hit_free: assert property (cache_hit |-> !stall_active)
    else $error("stall on hit");
  a_stall_max: assert property (stall_active ##1 stall_active |=> !stall_active)
    else $error("stall too long");
  a_stall_hold: assert property (stall_active |-> !exe_retire && !imem_data_en ##1 $stable(exe_addr))
    else $error("stall moved");
  a_miss_fetch: assert property ($fell(stall_active) |-> imem_data_en && exe_retire)
    else $error("no fetch after stall");
  a_idle_hold: assert property (idle_active && !irq_req |-> !imem_req && !exe_retire)
    else $error("issue while idle");
  a_irq_resume: assert property (idle_active && irq_req |-> irq_ack && imem_addr == irq_vector)
    else $error("no resume");
endmodule

/* testbench/fpc_mem_model.sv */
// Purpose: Instruction memory behind the fetch pipeline
// Assumes: Word of address a is a5a5a5 then a
// Notes: Toggles outside the data phase
`timescale 1ns/1ps
module fpc_mem_model
  import fpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic imem_req,
  input wire logic stall_active,
  input wire logic imem_data_en,
  input wire logic [ADDR_W-1:0] imem_addr,
  output logic [INSTR_W-1:0] imem_rdata
);
  logic [ADDR_W-1:0] f2_reg = '0;
  logic [INSTR_W-1:0] old_reg = '0;
  always_ff @(posedge clk_sys) begin
    if (imem_req && !stall_active) begin
      f2_reg <= imem_addr;
    end
    old_reg <= imem_rdata;
  end
  assign imem_rdata = imem_data_en ? {24'ha5a5a5, f2_reg} : ~old_reg;
endmodule

/* testbench/fpc_fetch_pipe_tb_top.sv */
// Purpose: Self-checking bench of the fetch pipeline
// Assumes: Loop 0..7 branching back from 7
// Notes: Stall and hit cycles counted per run
`timescale 1ns/1ps
module fpc_fetch_pipe_tb_top;
  import fpc_pkg::*;
  localparam logic [ADDR_W-1:0] NO = 24'hffffff;
  localparam logic [ADDR_W-1:0] FAR = 24'h010000;
  localparam logic [ADDR_W-1:0] VEC = 24'h000040;
  logic clk_sys = 0;
  logic rst = 1;
  logic irq_req = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [BUS_AW-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, imem_req, imem_data_en, dec_valid, progbus_addr_vld;
  logic databus_addr_vld, progbus_xfer, databus_xfer, irq_ack, exe_retire;
  logic exe_mem_wr, exe_reg_wr, idle_active, stall_active, cache_hit;
  logic [ADDR_W-1:0] imem_addr, dec_addr, progbus_addr, databus_addr, irq_ret_addr, exe_addr;
  logic [ADDR_W-1:0] pa_at = NO, da_at = NO, pb = FAR, idle_at = NO;
  logic [INSTR_W-1:0] imem_rdata, dec_instr, exe_instr;
  fpc_info_t dec_info;
  int err_count = 0, total_checks = 0, n_st = 0, n_hit = 0, n_br = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  fpc_fetch_pipe fpc_fetch_pipe_i (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .imem_addr,
    .imem_req, .imem_data_en, .imem_rdata, .dec_addr, .dec_instr, .dec_valid, .dec_info,
    .progbus_addr, .progbus_addr_vld, .databus_addr, .databus_addr_vld, .progbus_xfer,
    .databus_xfer, .io_bus_req(1'b0), .io_bus_addr(FAR), .irq_req, .irq_vector(VEC),
    .irq_ack, .irq_ret_addr, .exe_retire, .exe_addr, .exe_instr, .exe_mem_wr, .exe_reg_wr,
    .idle_active, .stall_active, .cache_hit);
  fpc_mem_model fpc_mem_model_i (.clk_sys, .imem_req, .stall_active, .imem_data_en,
    .imem_addr, .imem_rdata);
  // Decoder and address generators
  always_comb begin
    dec_info = '0;
    dec_info.prog_acc = dec_valid && dec_addr == pa_at;
    dec_info.prog_addr = pb;
    dec_info.data_acc = dec_valid && dec_addr == da_at;
    dec_info.data_addr = 24'h000200;
    dec_info.branch = dec_valid && dec_addr == 24'h000007;
    dec_info.idle = dec_valid && dec_addr == idle_at;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
    if (!rst && stall_active) n_st++;
    if (!rst && cache_hit) n_hit++;
    if (!rst && exe_retire) begin
      chk(exe_instr, {24'ha5a5a5, exe_addr});
      if (exe_addr == 24'h000007) n_br++;
    end
  end
  task automatic bus(input logic w, input logic [BUS_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1;
    pa_at <= NO;
    da_at <= NO;
    repeat (12) @(posedge clk_sys);
    rst <= 0;
  endtask
  task automatic go(input logic [23:0] p, d, b, input int n, st, hit);
    n_br = 0;
    while (n_br < 1) @(posedge clk_sys);
    pa_at <= p;
    da_at <= d;
    pb <= b;
    n_br = 0;
    n_st = 0;
    n_hit = 0;
    while (n_br < n) @(posedge clk_sys);
    pa_at <= NO;
    da_at <= NO;
    chk(n_st, st);
    chk(n_hit, hit);
  endtask
  initial begin
    do_reset();
    bus(0, REG_MODE, 0);
    chk(rd, MODE_RST);
    bus(0, 4'hc, 0);
    chk(rd, 0);
    go(24'h2, NO, FAR, 3, 1, 2);
    bus(1, REG_FLUSH, 1);
    go(24'h2, NO, FAR, 1, 1, 0);
    bus(1, REG_MODE, 32'h0008_0000);
    go(24'h2, NO, FAR, 1, 0, 1);
    bus(1, REG_MODE, 32'hffff_ffff);
    bus(0, REG_MODE, 0);
    chk(rd, MODE_MASK);
    go(24'h2, NO, FAR, 2, 2, 0);
    bus(1, REG_MODE, 32'h0008_0000);
    bus(1, REG_FLUSH, 1);
    go(24'h2, NO, FAR, 2, 2, 0);
    do_reset();
    go(NO, 24'h2, FAR, 2, 2, 0);
    go(24'h2, NO, FAR, 1, 1, 0);
    do_reset();
    go(24'h2, 24'h2, 24'h000100, 2, 2, 1);
    do_reset();
    idle_at <= 24'h000003;
    while (idle_active !== 1'b1) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(imem_req, 0);
    chk(irq_ret_addr, 24'h000004);
    @(posedge clk_sys);
    irq_req <= 1;
    @(negedge clk_sys);
    chk({irq_ack, imem_addr}, {1'b1, VEC});
    @(posedge clk_sys);
    irq_req <= 0;
    summarize();
  end
endmodule
bind fpc_fetch_pipe fpc_fetch_pipe_assertions fpc_fetch_pipe_assertions_i (.clk_sys, .rst,
  .avs_read, .avs_write, .avs_waitrequest, .imem_addr, .imem_req, .imem_data_en, .exe_addr,
  .irq_req, .irq_vector, .irq_ack, .exe_retire, .idle_active, .stall_active, .cache_hit);
